// ### inc/ues_defines.svh
// Function
// (RULE_01) Device mode: token CRC5 failure sets flag bit 1.
// (RULE_02) Host mode: bit 1 flags busy link when frame countdown hits zero.
// (RULE_03) Packet identifier check failure sets flag bit 0.
// (RULE_04) Late bus grant or truncated packet sets memory-transfer error flag.
// (RULE_05) More than sixteen idle bit times after end-of-packet sets time-out.
// (RULE_06) Per-flag enable bits 7..0, reset zero, gate the error summary.
// (RULE_07) Error summary reaches module interrupt only with error enable set.
// (RULE_08) Status bits 7..4 give last endpoint number 0..15.
// (RULE_09) Status bit 3 is one for transmit, zero for receive.
// (RULE_10) Status bit 2 is one for odd bank, zero for even.
// (RULE_11) Status is head of four-entry FIFO, valid while done flag set.
// (RULE_12) Clearing the done flag pops the status FIFO.
// (RULE_13) Control bits 7 and 6 show live J state and single-ended zero.
// (RULE_14) Device mode: bit 5 disables processing, set by SETUP, software clears.
// (RULE_15) Host mode: bit 5 reads one while a token executes.
// (RULE_16) Host software checks token busy before writing a new token.
// (RULE_17) Host mode: control bit 4 drives bus reset while one.
// (RULE_18) Control bit 3 enables host; any change resets host control logic.
// (RULE_19) Software holds resume 10 ms as function, 25 ms as host.
// (RULE_20) Bit 2 drives resume; host appends low-speed end-of-packet on clear.
// (RULE_21) Bits 31..8 read zero; status bits 1 and 0 read zero.
// (RULE_22) Hardware sets error flags; writing one clears, zero no effect.
// (RULE_23) Host mode with frame-start enable sends start-of-frame every ms.
// (RULE_24) No new completion reported while all four FIFO entries are full.
`ifndef UES_DEFINES_SVH
`define UES_DEFINES_SVH
`define UES_OFS_ERR_FLAGS 6'h00
`define UES_OFS_ERR_EN 6'h04
`define UES_OFS_STATUS 6'h08
`define UES_OFS_CONTROL 6'h0C
`define UES_OFS_IRQ_EN 6'h10
`define UES_OFS_IRQ_FLAGS 6'h14
`define UES_ERR_PID 0
`define UES_ERR_CRC5_EOF 1
`define UES_ERR_CRC16 2
`define UES_ERR_DSIZE 3
`define UES_ERR_TOUT 4
`define UES_ERR_MEM 5
`define UES_ERR_BMX 6
`define UES_ERR_STUFF 7
`define UES_CON_LINE_J_STATE 7
`define UES_CON_SE0 6
`define UES_CON_PKT 5
`define UES_CON_BUSRST 4
`define UES_CON_HOST 3
`define UES_CON_RESUME 2
`define UES_CON_BANKRST 1
`define UES_CON_EN 0
`define UES_IE_ERR 1
`define UES_IF_TRN 3
`define UES_IF_ERR 1
`define UES_FIFO_DEPTH 4
`define UES_CLK_HZ 40000000
`define UES_BIT_NS 83
`define UES_TURN_BITS 16
`define UES_TURN_CYC ((`UES_TURN_BITS * `UES_BIT_NS * 40 + 999) / 1000)
`define UES_FRAME_US 1000
`define UES_FRAME_CYC (`UES_FRAME_US * 40)
`define UES_LSEOP_NS 1330
`define UES_LSEOP_CYC ((`UES_LSEOP_NS * 40) / 1000)
`endif

// ### inc/ues_pkg.sv
package ues_pkg;
   typedef enum logic [1:0] {
      UES_RS_IDLE = 2'b00,
      UES_RS_DRIVE = 2'b01,
      UES_RS_EOP = 2'b11
   } ues_resume_t;
   typedef struct packed {
      logic [5:0] ep_info;
   } ues_entry_t;
endpackage

// ### rtl/ues_stat_fifo.sv
`timescale 1ns/1ps
module ues_stat_fifo (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic push,
   input wire logic [5:0] push_data,
   input wire logic pop,
   output logic full,
   output logic empty,
   output logic [5:0] head
);
   import ues_pkg::*;
   typedef struct packed {
      logic [3:0][5:0] mem;
      logic [1:0] rd;
      logic [1:0] wr;
      logic [2:0] cnt;
   } ues_fifo_t;
   ues_fifo_t st_reg, st_next;
   logic do_push, do_pop;
   // =========================
   // Four-entry queue
   always_comb begin
      st_next = st_reg;
      do_pop = pop && (st_reg.cnt != 3'h0);
      do_push = push && (st_reg.cnt != 3'h4);
      if (do_push) begin
         st_next.mem[st_reg.wr] = push_data;
         st_next.wr = st_reg.wr + 2'h1;
      end
      if (do_pop) begin
         st_next.rd = st_reg.rd + 2'h1;
      end
      if (do_push && !do_pop) begin
         st_next.cnt = st_reg.cnt + 3'h1;
      end else if (do_pop && !do_push) begin
         st_next.cnt = st_reg.cnt - 3'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign full = (st_reg.cnt == 3'h4);
   assign empty = (st_reg.cnt == 3'h0);
   assign head = st_reg.mem[st_reg.rd];
endmodule

// ### rtl/ues_core.sv
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "ues_defines.svh"
module ues_core (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic line_j_pin,
   input wire logic line_se0_pin,
   input wire logic ev_token_crc_bad,
   input wire logic ev_pid_bad,
   input wire logic ev_crc16_bad,
   input wire logic ev_dsize_bad,
   input wire logic ev_stuff_bad,
   input wire logic ev_bmx_bad,
   input wire logic ev_grant_late,
   input wire logic ev_truncated,
   input wire logic link_busy,
   input wire logic eop_seen,
   input wire logic resp_seen,
   input wire logic setup_seen,
   input wire logic token_start,
   input wire logic token_end,
   input wire logic trn_valid,
   input wire logic [3:0] trn_endpoint,
   input wire logic trn_tx,
   input wire logic trn_odd,
   output logic trn_ready,
   output logic module_irq,
   output logic bus_reset_out,
   output logic resume_out,
   output logic lseop_out,
   output logic sof_pulse,
   output logic host_logic_reset,
   output logic processing_disabled
);
   import ues_pkg::*;
   typedef struct packed {
      logic [1:0] j_sync;
      logic [1:0] se0_sync;
      logic [7:0] err_flags;
      logic [7:0] err_en;
      logic [7:0] ie;
      logic [7:0] con;
      logic trn_if;
      logic tok_busy;
      logic waiting;
      logic [9:0] turn_cnt;
      logic [15:0] frame_cnt;
      ues_resume_t rs;
      logic [6:0] eop_cnt;
      logic [31:0] rdata;
      logic ack;
      logic irq;
      logic sof;
      logic hrst;
      logic busrst;
      logic rsout;
      logic lsout;
      logic wreq;
      logic pdis;
   } ues_state_t;
   ues_state_t s_reg, s_next;
   logic fifo_full, fifo_empty, fifo_pop, fifo_push;
   logic [5:0] fifo_head;
   logic wr, rd, host, frame_zero;
   logic [7:0] err_set, stat_val, con_val;

   ues_stat_fifo u_fifo (
      .core_clk(core_clk),
      .reset(reset || s_reg.hrst),
      .push(fifo_push),
      .push_data({trn_endpoint, trn_tx, trn_odd}), // [RULE_09] [RULE_10]
      .pop(fifo_pop),
      .full(fifo_full),
      .empty(fifo_empty),
      .head(fifo_head)
   );

   // Write lands on the edge that completes the transfer, one edge after the wait state ends
   assign wr = avs_write && s_reg.ack;
   assign rd = avs_read && !s_reg.ack;
   assign host = s_reg.con[`UES_CON_HOST];
   assign frame_zero = (s_reg.frame_cnt == 16'h0000);
   assign fifo_push = trn_valid && !fifo_full; // [RULE_24]
   assign trn_ready = !fifo_full; // [RULE_24]
   assign fifo_pop = wr && (avs_address == `UES_OFS_IRQ_FLAGS)
      && avs_writedata[`UES_IF_TRN] && s_reg.trn_if; // [RULE_12]

   // =========================
   // Error sources
   always_comb begin
      err_set = 8'h00;
      err_set[`UES_ERR_PID] = ev_pid_bad; // [RULE_03]
      err_set[`UES_ERR_CRC5_EOF] = host ? (frame_zero && link_busy
         && s_reg.con[`UES_CON_EN]) // [RULE_02]
         : ev_token_crc_bad; // [RULE_01]
      err_set[`UES_ERR_CRC16] = ev_crc16_bad;
      err_set[`UES_ERR_DSIZE] = ev_dsize_bad;
      err_set[`UES_ERR_TOUT] = s_reg.waiting
         && (s_reg.turn_cnt == 10'(`UES_TURN_CYC)) && !resp_seen; // [RULE_05]
      err_set[`UES_ERR_MEM] = ev_grant_late || ev_truncated; // [RULE_04]
      err_set[`UES_ERR_BMX] = ev_bmx_bad;
      err_set[`UES_ERR_STUFF] = ev_stuff_bad;
   end

   assign stat_val = fifo_empty ? 8'h00 : {fifo_head, 2'b00}; // [RULE_21]
   always_comb begin
      con_val = s_reg.con;
      con_val[`UES_CON_LINE_J_STATE] = s_reg.j_sync[1]; // [RULE_13]
      con_val[`UES_CON_SE0] = s_reg.se0_sync[1]; // [RULE_13]
      if (host) begin
         con_val[`UES_CON_PKT] = s_reg.tok_busy; // [RULE_15]
      end
   end

   // =========================
   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.j_sync = {s_reg.j_sync[0], line_j_pin};
      s_next.se0_sync = {s_reg.se0_sync[0], line_se0_pin};
      s_next.ack = (avs_read || avs_write) && !s_reg.ack;
      s_next.hrst = 1'b0;
      s_next.sof = 1'b0;
      // Flags: set wins over clear
      if (wr && avs_address == `UES_OFS_ERR_FLAGS) begin
         s_next.err_flags = s_reg.err_flags & ~avs_writedata[7:0]; // [RULE_22]
      end
      s_next.err_flags = s_next.err_flags | err_set; // [RULE_22]
      if (wr && avs_address == `UES_OFS_ERR_EN) begin
         s_next.err_en = avs_writedata[7:0]; // [RULE_06]
      end
      if (wr && avs_address == `UES_OFS_IRQ_EN) begin
         s_next.ie = avs_writedata[7:0];
      end
      if (wr && avs_address == `UES_OFS_CONTROL) begin
         s_next.con[5:0] = avs_writedata[5:0];
         if (avs_writedata[`UES_CON_HOST] != host) begin
            s_next.hrst = 1'b1; // [RULE_18]
         end
      end
      if (!host && setup_seen) begin
         s_next.con[`UES_CON_PKT] = 1'b1; // [RULE_14]
      end
      s_next.con[`UES_CON_BANKRST] = 1'b0;
      // Done flag tracks FIFO head
      s_next.trn_if = !fifo_empty && !fifo_pop
         || fifo_push && fifo_empty; // [RULE_11]
      if (fifo_pop && fifo_push) begin
         s_next.trn_if = 1'b1;
      end else if (fifo_pop) begin
         s_next.trn_if = 1'b0;
      end
      if (token_start) begin
         s_next.tok_busy = 1'b1;
      end else if (token_end) begin
         s_next.tok_busy = 1'b0;
      end
      // Turnaround watch
      if (eop_seen) begin
         s_next.waiting = 1'b1;
         s_next.turn_cnt = 10'h000;
      end else if (resp_seen || err_set[`UES_ERR_TOUT]) begin
         s_next.waiting = 1'b0;
      end else if (s_reg.waiting) begin
         s_next.turn_cnt = s_reg.turn_cnt + 10'h001;
      end
      // Frame timer
      if (host && s_reg.con[`UES_CON_EN]) begin
         if (frame_zero) begin
            s_next.frame_cnt = 16'(`UES_FRAME_CYC - 1);
            s_next.sof = 1'b1; // [RULE_23]
         end else begin
            s_next.frame_cnt = s_reg.frame_cnt - 16'h0001;
         end
      end else begin
         s_next.frame_cnt = 16'(`UES_FRAME_CYC - 1);
      end
      // Resume sequencer
      case (s_reg.rs)
         UES_RS_IDLE: begin
            if (s_reg.con[`UES_CON_RESUME]) begin
               s_next.rs = UES_RS_DRIVE;
            end
         end
         UES_RS_DRIVE: begin
            if (!s_reg.con[`UES_CON_RESUME]) begin
               s_next.rs = host ? UES_RS_EOP : UES_RS_IDLE; // [RULE_20]
               s_next.eop_cnt = 7'(`UES_LSEOP_CYC);
            end
         end
         UES_RS_EOP: begin
            if (s_reg.eop_cnt == 7'h00) begin
               s_next.rs = UES_RS_IDLE;
            end else begin
               s_next.eop_cnt = s_reg.eop_cnt - 7'h01;
            end
         end
         default: s_next.rs = UES_RS_IDLE;
      endcase
      if (s_reg.hrst) begin
         // Queue is flushed, so no entry is left to flag
         s_next.trn_if = 1'b0;
         s_next.tok_busy = 1'b0;
         s_next.frame_cnt = 16'(`UES_FRAME_CYC - 1);
         s_next.rs = UES_RS_IDLE;
      end
      // Outputs
      s_next.irq = (|(s_reg.err_flags & s_reg.err_en)) // [RULE_06]
         && s_reg.ie[`UES_IE_ERR]; // [RULE_07]
      s_next.busrst = host && s_reg.con[`UES_CON_BUSRST]; // [RULE_17]
      s_next.rsout = (s_reg.rs == UES_RS_DRIVE); // [RULE_20]
      s_next.lsout = (s_reg.rs == UES_RS_EOP);
      s_next.wreq = !s_next.ack;
      s_next.pdis = s_next.con[`UES_CON_PKT] && !s_next.con[`UES_CON_HOST];
      s_next.rdata = 32'h0;
      if (rd) begin
         case (avs_address)
            `UES_OFS_ERR_FLAGS: s_next.rdata = {24'h0, s_reg.err_flags};
            `UES_OFS_ERR_EN: s_next.rdata = {24'h0, s_reg.err_en};
            `UES_OFS_STATUS: s_next.rdata = {24'h0, stat_val}; // [RULE_08]
            `UES_OFS_CONTROL: s_next.rdata = {24'h0, con_val}; // [RULE_21]
            `UES_OFS_IRQ_EN: s_next.rdata = {24'h0, s_reg.ie};
            `UES_OFS_IRQ_FLAGS: s_next.rdata = {28'h0, s_reg.trn_if,
               1'b0, s_reg.irq, 1'b0};
            default: s_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.frame_cnt <= 16'(`UES_FRAME_CYC - 1);
         s_reg.wreq <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_readdata = s_reg.rdata;
   assign avs_waitrequest = s_reg.wreq;
   assign module_irq = s_reg.irq;
   assign bus_reset_out = s_reg.busrst;
   assign resume_out = s_reg.rsout;
   assign lseop_out = s_reg.lsout;
   assign sof_pulse = s_reg.sof;
   assign host_logic_reset = s_reg.hrst;
   assign processing_disabled = s_reg.pdis;

   // =========================
   // Checks
   property p_pid;
      @(posedge core_clk) disable iff (reset)
      ev_pid_bad |=> s_reg.err_flags[`UES_ERR_PID];
   endproperty
   a_pid: assert property (p_pid) else $error("pid flag"); // [RULE_03]
   property p_crc5;
      @(posedge core_clk) disable iff (reset)
      !host && ev_token_crc_bad |=> s_reg.err_flags[`UES_ERR_CRC5_EOF];
   endproperty
   a_crc5: assert property (p_crc5) else $error("crc5"); // [RULE_01]
   property p_mem;
      @(posedge core_clk) disable iff (reset)
      ev_truncated |=> s_reg.err_flags[`UES_ERR_MEM];
   endproperty
   a_mem: assert property (p_mem) else $error("mem"); // [RULE_04]
   property p_irq;
      @(posedge core_clk) disable iff (reset)
      !s_reg.ie[`UES_IE_ERR] |=> !module_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq gate"); // [RULE_07]
   property p_en;
      @(posedge core_clk) disable iff (reset)
      (s_reg.err_en == 8'h00) |=> !module_irq;
   endproperty
   a_en: assert property (p_en) else $error("enable gate"); // [RULE_06]
   property p_full;
      @(posedge core_clk) disable iff (reset)
      fifo_full && !fifo_pop && !s_reg.hrst
         |=> fifo_full && $stable(fifo_head);
   endproperty
   a_full: assert property (p_full) else $error("full"); // [RULE_24]
   property p_setup;
      @(posedge core_clk) disable iff (reset)
      !host && setup_seen && !s_reg.hrst |=> s_reg.con[`UES_CON_PKT];
   endproperty
   a_setup: assert property (p_setup) else $error("setup"); // [RULE_14]
   property p_hrst;
      @(posedge core_clk) disable iff (reset)
      $changed(host) |-> $past(s_reg.hrst) == 1'b0 ##0 s_reg.hrst;
   endproperty
   a_hrst: assert property (p_hrst) else $error("host rst"); // [RULE_18]
   property p_tout;
      @(posedge core_clk) disable iff (reset)
      $rose(s_reg.err_flags[`UES_ERR_TOUT])
         |-> $past(s_reg.turn_cnt) == 10'(`UES_TURN_CYC);
   endproperty
   a_tout: assert property (p_tout) else $error("turnaround"); // [RULE_05]
   property p_trn;
      @(posedge core_clk) disable iff (reset)
      s_reg.trn_if |-> !fifo_empty;
   endproperty
   a_trn: assert property (p_trn) else $error("done flag"); // [RULE_11]
   property p_lseop;
      @(posedge core_clk) disable iff (reset)
      host && !s_reg.hrst && s_reg.rs == UES_RS_DRIVE
         && $fell(s_reg.con[`UES_CON_RESUME]) |-> ##2 lseop_out;
   endproperty
   a_lseop: assert property (p_lseop) else $error("ls eop"); // [RULE_20]
   property p_rsdrv;
      @(posedge core_clk) disable iff (reset)
      s_reg.con[`UES_CON_RESUME] && s_reg.rs == UES_RS_DRIVE |=> resume_out;
   endproperty
   a_rsdrv: assert property (p_rsdrv) else $error("resume"); // [RULE_20]
   property p_busrst;
      @(posedge core_clk) disable iff (reset)
      host && s_reg.con[`UES_CON_BUSRST] |=> bus_reset_out;
   endproperty
   a_busrst: assert property (p_busrst) else $error("bus reset"); // [RULE_17]
   property p_sof;
      @(posedge core_clk) disable iff (reset)
      !host |=> !sof_pulse;
   endproperty
   a_sof: assert property (p_sof) else $error("frame start"); // [RULE_23]
   property p_wreq;
      @(posedge core_clk) disable iff (reset)
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wreq: assert property (p_wreq) else $error("wait state");
   c_irq: cover property (@(posedge core_clk) module_irq);
   c_full: cover property (@(posedge core_clk) fifo_full);
   c_lseop: cover property (@(posedge core_clk) lseop_out);
   c_sof: cover property (@(posedge core_clk) sof_pulse);
endmodule

// ### bench/ues_link_model.sv
`timescale 1ns/1ps
module ues_link_model (
   input wire logic core_clk,
   input wire logic trn_ready,
   output logic line_j_pin,
   output logic line_se0_pin,
   output logic trn_valid,
   output logic [3:0] trn_endpoint,
   output logic trn_tx,
   output logic trn_odd
);
   initial begin
      {line_j_pin, line_se0_pin, trn_valid} = '0;
      {trn_endpoint, trn_tx, trn_odd} = '0;
   end
   // Line levels seen by the block
   task automatic line(input logic j, input logic se0);
      @(posedge core_clk);
      line_j_pin <= j;
      line_se0_pin <= se0;
   endtask
   // Completion held until the block takes it
   task automatic post(input logic [5:0] info);
      int n;
      n = 0;
      @(posedge core_clk);
      trn_valid <= 1'b1;
      {trn_endpoint, trn_tx, trn_odd} <= info;
      do begin
         @(posedge core_clk);
         n++;
      end while (trn_ready !== 1'b1 && n < 500);
      trn_valid <= 1'b0;
      {trn_endpoint, trn_tx, trn_odd} <= ~info;
      if (n >= 500) begin
         tb_top.chk("link wait", 32'h0, 32'h1);
         tb_top.end_of_test();
      end
   endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [3:0] ev;
      logic [7:0] flag;
   } ues_row_t;
   logic core_clk, reset, avs_read, avs_write, link_busy;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic avs_waitrequest, trn_ready, module_irq, bus_reset_out, resume_out;
   logic lseop_out, sof_pulse, host_logic_reset, processing_disabled;
   logic line_j_pin, line_se0_pin, trn_valid, trn_tx, trn_odd;
   logic [3:0] trn_endpoint;
   logic [12:0] ev;
   logic [2:0] mon;
   int error_cnt, checked;
   ues_row_t rows [8];
   logic [5:0] fe [5];
   assign mon = {host_logic_reset, lseop_out, sof_pulse};
   ues_core i_ues_core (.core_clk(core_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .line_j_pin(line_j_pin), .line_se0_pin(line_se0_pin),
      .ev_pid_bad(ev[0]), .ev_token_crc_bad(ev[1]), .ev_crc16_bad(ev[2]),
      .ev_dsize_bad(ev[3]), .ev_grant_late(ev[4]), .ev_truncated(ev[5]),
      .ev_bmx_bad(ev[6]), .ev_stuff_bad(ev[7]), .link_busy(link_busy),
      .eop_seen(ev[8]), .resp_seen(ev[9]), .setup_seen(ev[10]),
      .token_start(ev[11]), .token_end(ev[12]), .trn_valid(trn_valid),
      .trn_endpoint(trn_endpoint), .trn_tx(trn_tx), .trn_odd(trn_odd),
      .trn_ready(trn_ready), .module_irq(module_irq),
      .bus_reset_out(bus_reset_out), .resume_out(resume_out),
      .lseop_out(lseop_out), .sof_pulse(sof_pulse),
      .host_logic_reset(host_logic_reset),
      .processing_disabled(processing_disabled));
   ues_link_model i_ues_link_model (.core_clk(core_clk),
      .trn_ready(trn_ready), .line_j_pin(line_j_pin),
      .line_se0_pin(line_se0_pin), .trn_valid(trn_valid),
      .trn_endpoint(trn_endpoint), .trn_tx(trn_tx), .trn_odd(trn_odd));
   // ==========================================
   // Reporting and bus tasks
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         chk("bus wait", 32'h0, 32'h1);
         end_of_test();
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask
   task automatic wait_hi(input int b, input int lim);
      int n;
      for (n = 0; n < lim && mon[b] !== 1'b1; n++) @(posedge core_clk);
      chk($sformatf("output %0d", b), 32'h1, {31'h0, mon[b]});
      if (n >= lim) end_of_test();
   endtask
   // ==========================================
   // Clock, watchdog, stimulus
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      chk("run time", 32'h0, 32'h1);
      end_of_test();
   end
   initial begin
      {reset, avs_read, avs_write, link_busy} = 4'hF << 3;
      {avs_address, avs_writedata, ev} = '0;
      rows = '{'{4'h0, 8'h01}, '{4'h1, 8'h02}, '{4'h2, 8'h04},
               '{4'h3, 8'h08}, '{4'h4, 8'h20}, '{4'h5, 8'h20},
               '{4'h6, 8'h40}, '{4'h7, 8'h80}};
      fe = '{6'h3F, 6'h01, 6'h26, 6'h1A, 6'h15};
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      rd(6'h00, 32'h0);
      rd(6'h04, 32'h0);
      rd(6'h0C, 32'h0);
      rd(6'h3C, 32'h0);
      wr(6'h3C, 32'hFFFFFFFF);
      wr(6'h04, 32'hFFFFFFFF);
      rd(6'h04, 32'hFF);
      wr(6'h10, 32'h2);
      for (int i = 0; i < 8; i++) begin
         pulse(rows[i].ev);
         rd(6'h00, {24'h0, rows[i].flag});
         chk("irq set", 32'h1, {31'h0, module_irq});
         wr(6'h00, 32'h0);
         rd(6'h00, {24'h0, rows[i].flag});
         wr(6'h00, {24'h0, rows[i].flag});
         rd(6'h00, 32'h0);
         chk("irq clear", 32'h0, {31'h0, module_irq});
      end
      pulse(8);
      repeat (60) @(posedge core_clk);
      rd(6'h00, 32'h10);
      wr(6'h00, 32'h10);
      pulse(8);
      pulse(9);
      repeat (60) @(posedge core_clk);
      rd(6'h00, 32'h0);
      wr(6'h04, 32'h01);
      pulse(2);
      rd(6'h00, 32'h04);
      chk("irq masked", 32'h0, {31'h0, module_irq});
      wr(6'h04, 32'hFF);
      wr(6'h10, 32'h0);
      repeat (3) @(posedge core_clk);
      chk("irq off", 32'h0, {31'h0, module_irq});
      wr(6'h10, 32'h2);
      repeat (3) @(posedge core_clk);
      chk("irq on", 32'h1, {31'h0, module_irq});
      wr(6'h00, 32'hFF);
      i_ues_link_model.line(1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      rd(6'h0C, 32'h80);
      i_ues_link_model.line(1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      rd(6'h0C, 32'h40);
      i_ues_link_model.line(1'b0, 1'b0);
      pulse(10);
      repeat (4) @(posedge core_clk);
      rd(6'h0C, 32'h20);
      chk("disabled", 32'h1, {31'h0, processing_disabled});
      wr(6'h0C, 32'h0);
      rd(6'h0C, 32'h0);
      chk("enabled", 32'h0, {31'h0, processing_disabled});
      fork
         for (int k = 0; k < 5; k++) i_ues_link_model.post(fe[k]);
      join_none
      repeat (20) @(posedge core_clk);
      chk("ready full", 32'h0, {31'h0, trn_ready});
      for (int k = 0; k < 5; k++) begin
         rd(6'h14, 32'h08);
         rd(6'h08, {24'h0, fe[k], 2'b00});
         wr(6'h14, 32'h08);
         repeat (4) @(posedge core_clk);
      end
      rd(6'h14, 32'h0);
      rd(6'h08, 32'h0);
      wr(6'h0C, 32'h08);
      wait_hi(2, 10);
      pulse(11);
      repeat (2) @(posedge core_clk);
      rd(6'h0C, 32'h28);
      pulse(12);
      repeat (2) @(posedge core_clk);
      rd(6'h0C, 32'h08);
      wr(6'h0C, 32'h18);
      repeat (2) @(posedge core_clk);
      chk("bus reset", 32'h1, {31'h0, bus_reset_out});
      wr(6'h0C, 32'h08);
      repeat (2) @(posedge core_clk);
      chk("bus reset end", 32'h0, {31'h0, bus_reset_out});
      wr(6'h0C, 32'h0C);
      repeat (3) @(posedge core_clk);
      chk("resume", 32'h1, {31'h0, resume_out});
      wr(6'h0C, 32'h08);
      wait_hi(1, 60);
      link_busy <= 1'b1;
      wr(6'h0C, 32'h09);
      wait_hi(0, 41000);
      repeat (3) @(posedge core_clk);
      rd(6'h00, 32'h02);
      link_busy <= 1'b0;
      wr(6'h0C, 32'h0);
      wait_hi(2, 10);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(6'h04, 32'h0);
      end_of_test();
   end
endmodule
